// ==== rtl/csbe_pkg.sv ====
/*
 * Constants, opcodes and state encoding for the counter, skip and branch executor.
 * Assumes an 8-bit data path, 7-bit file addresses and a 13-bit program counter.
 */
package csbe_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int DATA_W    = 8;
   localparam int FADDR_W   = 7;
   localparam int LIT_W     = 11;
   localparam int PC_W      = 13;
   localparam int LATCH_W   = 5;
   localparam int FILE_DEPTH = 128;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LATCH_SEL_HI  = 4;
   localparam int LATCH_SEL_LO  = 3;
   localparam int PC_HI_TOP     = 12;
   localparam int PC_HI_BOT     = 11;
   localparam int PC_LO_TOP     = 10;
   localparam int OR_LIT_TOP    = 7;

   // ************************************************************
   // Values after reset and step counts
   // ************************************************************
   localparam logic [DATA_W-1:0] ACC_RST      = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST       = 13'h0000;
   localparam logic [DATA_W-1:0] DATA_ONE     = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO    = 8'h00;
   localparam logic [PC_W-1:0]   PC_STEP      = 13'h0001;
   localparam logic [PC_W-1:0]   PC_SKIP_STEP = 13'h0002;
   localparam logic [1:0]        CYC_ONE      = 2'h1;
   localparam logic [1:0]        CYC_TWO      = 2'h2;

   // ************************************************************
   // Opcodes and states
   // ************************************************************
   typedef enum logic [2:0] {
      decrement_skip_zero_op    = 3'h0,
      increment_skip_zero_op    = 3'h1,
      increment_file_op         = 3'h2,
      literal_or_accumulator_op = 3'h3,
      unconditional_branch_op   = 3'h4,
      no_operation              = 3'h5
   } csbe_op_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_FETCH  = 2'h1,
      ST_EXEC   = 2'h3,
      ST_SECOND = 2'h2
   } csbe_state_t;

endpackage

// ==== rtl/csbe_mem_if.sv ====
/*
 * Link between the executor and its file register memory.
 * Assumes one writer (the executor) and a memory with registered read data.
 */
interface csbe_mem_if #(
   parameter int AW = 7,
   parameter int DW = 8
);
   logic [AW-1:0] addr;
   logic          wr_en;
   logic [DW-1:0] wr_data;
   logic [DW-1:0] rd_data;

   modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
   modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// ==== rtl/csbe_file_mem.sv ====
/*
 * File register memory: one write port, read data from a register.
 * Assumes the address is held for a cycle before its read data are used.
 */
module csbe_file_mem
   import csbe_pkg::*;
#(
   parameter int DEPTH = FILE_DEPTH
) (
   // Clock, reset and enable
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // Memory side of the link
   csbe_mem_if.mem   mb
);

   typedef struct packed {
      logic [DATA_W-1:0] rd;
   } csbe_mem_state_t;

   logic [DATA_W-1:0] mem_array [DEPTH];
   csbe_mem_state_t   st_ff;
   csbe_mem_state_t   nxt_st;

   // A read during a write returns the old contents.
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.rd = mem_array[mb.addr];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && mb.wr_en) begin
         mem_array[mb.addr] <= mb.wr_data;
      end
   end

   assign mb.rd_data = st_ff.rd;

endmodule

// ==== rtl/csbe_exec.sv ====
/*
 * Executor for five core instructions: decrement or increment with skip on zero,
 * plain increment, literal OR into the accumulator and the unconditional branch.
 * Assumes instructions arrive one at a time over a valid and ready handshake,
 * all inputs are synchronous to clk and the high latch is stable while busy.
 */
// How it works
// - Decrement-skip subtracts one; destination bit 0 to accumulator, 1 to file.
// - Decrement-skip zero result skips next instruction via a no-operation; flags kept.
// - Increment-skip adds one; destination bit 0 to accumulator, 1 to file.
// - Increment-skip zero result skips next instruction via a no-operation; flags kept.
// - Plain increment adds one, routes by destination, updates only the zero flag.
// - Literal OR merges accumulator with 8-bit literal, result to accumulator, zero updated.
// - Branch loads its 11-bit literal into program counter bits 10 to 0.
// - Branch copies latch bits 4 and 3 into counter bits 12 and 11.
// - Branch always takes two instruction cycles.
module csbe_exec
   import csbe_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   // Instruction handshake
   input  wire logic                instr_valid,
   output wire logic                instr_ready,
   input  wire logic [2:0]          instr_op,
   input  wire logic [FADDR_W-1:0]  instr_file_addr,
   input  wire logic                instr_dest,
   input  wire logic [LIT_W-1:0]    instr_literal,
   // Program counter high latch
   input  wire logic [LATCH_W-1:0]  program_counter_high_latch,
   // File register host access, idle only
   input  wire logic [FADDR_W-1:0]  fr_host_addr,
   input  wire logic                fr_host_we,
   input  wire logic [DATA_W-1:0]   fr_host_wdata,
   output wire logic [DATA_W-1:0]   fr_host_rdata,
   // Accumulator preload, idle only
   input  wire logic                acc_load_en,
   input  wire logic [DATA_W-1:0]   acc_load_data,
   // Core state and completion
   output wire logic [DATA_W-1:0]   accumulator,
   output wire logic                zero_flag,
   output wire logic [PC_W-1:0]     program_counter,
   output wire logic                instr_done,
   output wire logic [1:0]          instr_cycles,
   output wire logic                skip_taken
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      csbe_state_t        state;
      csbe_op_t           op;
      logic [FADDR_W-1:0] faddr;
      logic               dest;
      logic [LIT_W-1:0]   lit;
      logic [1:0]         pc_hi;
      logic [DATA_W-1:0]  acc;
      logic               zero;
      logic [PC_W-1:0]    pc;
      logic               done;
      logic [1:0]         cycles;
      logic               skip;
   } csbe_state_reg_t;

   localparam csbe_state_reg_t ST_RST = '{
      state: ST_IDLE, op: no_operation, faddr: '0, dest: 1'b0, lit: '0, pc_hi: '0,
      acc: ACC_RST, zero: 1'b0, pc: PC_RST, done: 1'b0, cycles: '0, skip: 1'b0};

   csbe_state_reg_t st_ff;
   csbe_state_reg_t nxt_st;

   csbe_mem_if #(.AW(FADDR_W), .DW(DATA_W)) mif ();

   function automatic logic is_zero8(input logic [DATA_W-1:0] v);
      return v == DATA_ZERO;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [DATA_W-1:0] res;
      logic              file_op;
      logic              do_skip;
      res          = DATA_ZERO;
      file_op      = 1'b0;
      do_skip      = 1'b0;
      nxt_st       = st_ff;
      nxt_st.done  = 1'b0;
      mif.addr     = st_ff.faddr;
      mif.wr_en    = 1'b0;
      mif.wr_data  = DATA_ZERO;
      case (st_ff.state)
         ST_IDLE: begin
            mif.addr    = fr_host_addr;
            mif.wr_en   = fr_host_we;
            mif.wr_data = fr_host_wdata;
            if (acc_load_en) begin
               nxt_st.acc = acc_load_data;
            end
            if (instr_valid) begin
               nxt_st.op    = csbe_op_t'(instr_op);
               nxt_st.faddr = instr_file_addr;
               nxt_st.dest  = instr_dest;
               nxt_st.lit   = instr_literal;
               nxt_st.pc_hi = program_counter_high_latch[LATCH_SEL_HI:LATCH_SEL_LO];
               nxt_st.state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            nxt_st.state = ST_EXEC;
         end
         ST_EXEC: begin
            nxt_st.state  = ST_IDLE;
            nxt_st.done   = 1'b1;
            nxt_st.cycles = CYC_ONE;
            nxt_st.skip   = 1'b0;
            nxt_st.pc     = st_ff.pc + PC_STEP;
            case (st_ff.op)
               decrement_skip_zero_op: begin
                  res     = mif.rd_data - DATA_ONE;
                  file_op = 1'b1;
                  do_skip = is_zero8(res);
               end
               increment_skip_zero_op: begin
                  res     = mif.rd_data + DATA_ONE;
                  file_op = 1'b1;
                  do_skip = is_zero8(res);
               end
               increment_file_op: begin
                  res         = mif.rd_data + DATA_ONE;
                  file_op     = 1'b1;
                  nxt_st.zero = is_zero8(res);
               end
               literal_or_accumulator_op: begin
                  nxt_st.acc  = st_ff.acc | st_ff.lit[OR_LIT_TOP:0];
                  nxt_st.zero = is_zero8(nxt_st.acc);
               end
               unconditional_branch_op: begin
                  nxt_st.pc[PC_LO_TOP:0]         = st_ff.lit;
                  nxt_st.pc[PC_HI_TOP:PC_HI_BOT] = st_ff.pc_hi;
                  nxt_st.state                   = ST_SECOND;
                  nxt_st.cycles                  = CYC_TWO;
                  nxt_st.done                    = 1'b0;
               end
               default: begin
               end
            endcase
            if (file_op) begin
               if (st_ff.dest) begin
                  mif.wr_en   = 1'b1;
                  mif.wr_data = res;
               end else begin
                  nxt_st.acc = res;
               end
            end
            // The discarded instruction is stepped over and a dead cycle stands in for it.
            if (do_skip) begin
               nxt_st.pc     = st_ff.pc + PC_SKIP_STEP;
               nxt_st.state  = ST_SECOND;
               nxt_st.cycles = CYC_TWO;
               nxt_st.skip   = 1'b1;
               nxt_st.done   = 1'b0;
            end
         end
         ST_SECOND: begin
            nxt_st.state = ST_IDLE;
            nxt_st.done  = 1'b1;
         end
         default: begin
            nxt_st.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= ST_RST;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   csbe_file_mem #(.DEPTH(FILE_DEPTH)) u_file_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .mb      (mif.mem)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign instr_ready     = (st_ff.state == ST_IDLE);
   assign fr_host_rdata   = mif.rd_data;
   assign accumulator     = st_ff.acc;
   assign zero_flag       = st_ff.zero;
   assign program_counter = st_ff.pc;
   assign instr_done      = st_ff.done;
   assign instr_cycles    = st_ff.cycles;
   assign skip_taken      = st_ff.skip;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !clk_en);

   logic in_exec;
   assign in_exec = (st_ff.state == ST_EXEC);

   dec_route_a: assert property (
      in_exec && st_ff.op == decrement_skip_zero_op |->
      (st_ff.dest ? (mif.wr_en && mif.wr_data == mif.rd_data - DATA_ONE) : !mif.wr_en))
      else $error("decrement result routed wrongly");
   dec_skip_a: assert property (
      in_exec && st_ff.op == decrement_skip_zero_op && mif.rd_data == DATA_ONE |=>
      st_ff.state == ST_SECOND && $stable(st_ff.zero) ##1 st_ff.done && st_ff.cycles == CYC_TWO)
      else $error("decrement to zero did not skip");
   inc_skip_acc_a: assert property (
      in_exec && st_ff.op == increment_skip_zero_op && !st_ff.dest |=>
      st_ff.acc == $past(mif.rd_data) + DATA_ONE)
      else $error("increment-skip accumulator wrong");
   inc_skip_pc_a: assert property (
      in_exec && st_ff.op == increment_skip_zero_op && mif.rd_data == 8'hFF |=>
      st_ff.pc == $past(st_ff.pc) + PC_SKIP_STEP && $stable(st_ff.zero) && st_ff.skip)
      else $error("increment to zero did not skip");
   inc_zero_a: assert property (
      in_exec && st_ff.op == increment_file_op |=>
      st_ff.zero == ($past(mif.rd_data) == 8'hFF) && st_ff.state == ST_IDLE)
      else $error("increment zero flag wrong");
   or_result_a: assert property (
      in_exec && st_ff.op == literal_or_accumulator_op |=>
      st_ff.acc == ($past(st_ff.acc) | $past(st_ff.lit[OR_LIT_TOP:0]))
      && st_ff.zero == is_zero8(st_ff.acc))
      else $error("literal OR result wrong");
   branch_low_a: assert property (
      in_exec && st_ff.op == unconditional_branch_op |=>
      st_ff.pc[PC_LO_TOP:0] == $past(st_ff.lit))
      else $error("branch low target wrong");
   branch_high_a: assert property (
      instr_ready && instr_valid && csbe_op_t'(instr_op) == unconditional_branch_op ##1
      st_ff.state == ST_FETCH ##1 st_ff.state == ST_EXEC |=>
      st_ff.pc[PC_HI_TOP:PC_HI_BOT] ==
      $past(program_counter_high_latch[LATCH_SEL_HI:LATCH_SEL_LO], 3)
      && $stable(st_ff.zero))
      else $error("branch high bits wrong");
   branch_two_a: assert property (
      in_exec && st_ff.op == unconditional_branch_op |=>
      !st_ff.done && st_ff.state == ST_SECOND ##1 st_ff.done && st_ff.cycles == CYC_TWO)
      else $error("branch did not take two cycles");
   dec_wrap_a: assert property (
      in_exec && st_ff.op == decrement_skip_zero_op && is_zero8(mif.rd_data) && !st_ff.dest
      |=> st_ff.acc == 8'hFF && !st_ff.skip)
      else $error("decrement did not wrap");

   dec_skip_c: cover property (in_exec && st_ff.op == decrement_skip_zero_op
      && mif.rd_data == DATA_ONE);
   branch_c: cover property (in_exec && st_ff.op == unconditional_branch_op ##2 st_ff.done);
   or_zero_c: cover property (in_exec && st_ff.op == literal_or_accumulator_op ##1 st_ff.zero);

endmodule

// ==== sim/tb_counter_skip_branch_or_exec.sv ====
/*
 * Self-checking bench for the counter, skip and branch executor.
 * Assumes the executor's assertions sit in its own files, and that the bench
 * alone drives every input port.
 */
module tb_counter_skip_branch_or_exec
   import csbe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals and reference state
   // ************************************************************
   logic                clk;
   logic                sys_rst;
   logic                clk_en;
   logic                instr_valid;
   logic [2:0]          instr_op;
   logic [FADDR_W-1:0]  instr_file_addr;
   logic                instr_dest;
   logic [LIT_W-1:0]    instr_literal;
   logic [LATCH_W-1:0]  program_counter_high_latch;
   logic [FADDR_W-1:0]  fr_host_addr;
   logic                fr_host_we;
   logic [DATA_W-1:0]   fr_host_wdata;
   logic                acc_load_en;
   logic [DATA_W-1:0]   acc_load_data;
   wire logic           instr_ready;
   wire logic [DATA_W-1:0] fr_host_rdata;
   wire logic [DATA_W-1:0] accumulator;
   wire logic           zero_flag;
   wire logic [PC_W-1:0] program_counter;
   wire logic           instr_done;
   wire logic [1:0]     instr_cycles;
   wire logic           skip_taken;
   logic [DATA_W-1:0]   m_file [FILE_DEPTH];
   logic [DATA_W-1:0]   m_acc;
   logic                m_z;
   logic [PC_W-1:0]     m_pc;
   int                  n_fail;
   int                  checked;
   int                  seed;
   int                  i;
   int                  j;

   csbe_exec u_dut (
      .clk                        (clk),
      .sys_rst                    (sys_rst),
      .clk_en                     (clk_en),
      .instr_valid                (instr_valid),
      .instr_ready                (instr_ready),
      .instr_op                   (instr_op),
      .instr_file_addr            (instr_file_addr),
      .instr_dest                 (instr_dest),
      .instr_literal              (instr_literal),
      .program_counter_high_latch (program_counter_high_latch),
      .fr_host_addr               (fr_host_addr),
      .fr_host_we                 (fr_host_we),
      .fr_host_wdata              (fr_host_wdata),
      .fr_host_rdata              (fr_host_rdata),
      .acc_load_en                (acc_load_en),
      .acc_load_data              (acc_load_data),
      .accumulator                (accumulator),
      .zero_flag                  (zero_flag),
      .program_counter            (program_counter),
      .instr_done                 (instr_done),
      .instr_cycles               (instr_cycles),
      .skip_taken                 (skip_taken)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic wrap_up();
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic host_wr(input logic [6:0] fa, input logic [7:0] v);
      @(posedge clk);
      fr_host_addr  <= fa;
      fr_host_wdata <= v;
      fr_host_we    <= 1'b1;
      @(posedge clk);
      fr_host_we    <= 1'b0;
      m_file[fa] = v;
   endtask

   task automatic host_rd(input logic [6:0] fa);
      @(posedge clk);
      fr_host_addr <= fa;
      repeat (2) @(posedge clk);
      #1;
      chk("file", {8'h00, fr_host_rdata}, {8'h00, m_file[fa]});
   endtask

   task automatic acc_load(input logic [7:0] v);
      @(posedge clk);
      acc_load_en   <= 1'b1;
      acc_load_data <= v;
      @(posedge clk);
      acc_load_en   <= 1'b0;
      m_acc = v;
   endtask

   // Works out the expected outcome, issues one instruction and compares.
   task automatic run_op(input logic [2:0] op, input logic [6:0] fa, input logic d,
                         input logic [10:0] lit, input logic [4:0] lat);
      logic [7:0] res;
      logic [1:0] cyc;
      logic       sk;
      int         n;
      res = DATA_ZERO;
      sk  = 1'b0;
      cyc = CYC_ONE;
      if (op == 3'h0) res = m_file[fa] - DATA_ONE;
      if (op == 3'h1 || op == 3'h2) res = m_file[fa] + DATA_ONE;
      if (op == 3'h3) res = m_acc | lit[7:0];
      if (op <= 3'h2 && d) m_file[fa] = res;
      if ((op <= 3'h2 && !d) || op == 3'h3) m_acc = res;
      if (op == 3'h2 || op == 3'h3) m_z = (res == DATA_ZERO);
      if (op <= 3'h1 && res == DATA_ZERO) begin
         sk  = 1'b1;
         cyc = CYC_TWO;
      end
      if (op == 3'h4) begin
         m_pc = {lat[4:3], lit};
         cyc  = CYC_TWO;
      end else begin
         m_pc = m_pc + (sk ? PC_SKIP_STEP : PC_STEP);
      end
      @(posedge clk);
      instr_op                   <= op;
      instr_file_addr            <= fa;
      instr_dest                 <= d;
      instr_literal              <= lit;
      program_counter_high_latch <= lat;
      instr_valid                <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      for (n = 1; n <= 8; n++) begin
         @(posedge clk);
         #1;
         if (instr_done === 1'b1) break;
      end
      if (n > 8) begin
         n_fail++;
         wrap_up();
      end
      chk("latency", 16'(n), (cyc == CYC_TWO) ? 16'h0003 : 16'h0002);
      chk("cycles", {14'h0000, instr_cycles}, {14'h0000, cyc});
      chk("accumulator", {8'h00, accumulator}, {8'h00, m_acc});
      chk("zero", {15'h0000, zero_flag}, {15'h0000, m_z});
      chk("pc", {3'h0, program_counter}, {3'h0, m_pc});
      if (op <= 3'h1) begin
         chk("skip", {15'h0000, skip_taken}, {15'h0000, sk});
      end
      if (op <= 3'h2 && d) host_rd(fa);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      n_fail = 0;
      checked = 0;
      seed = 97;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr_op = 3'h0;
      instr_file_addr = 7'h00;
      instr_dest = 1'b0;
      instr_literal = 11'h000;
      program_counter_high_latch = 5'h00;
      fr_host_addr = 7'h00;
      fr_host_we = 1'b0;
      fr_host_wdata = 8'h00;
      acc_load_en = 1'b0;
      acc_load_data = 8'h00;
      m_acc = ACC_RST;
      m_z = 1'b0;
      m_pc = PC_RST;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("rst_acc", {8'h00, accumulator}, {8'h00, ACC_RST});
      chk("rst_pc", {3'h0, program_counter}, {3'h0, PC_RST});
      chk("rst_ready", {15'h0000, instr_ready}, 16'h0001);
      for (i = 0; i < FILE_DEPTH; i++) host_wr(7'(i), 8'($random(seed)));
      // Boundary values of every file operation with both destinations.
      for (i = 0; i < 3; i++) begin
         for (j = 0; j < 8; j++) begin
            host_wr(7'h7F, (j[1:0] == 2'h0) ? 8'h00 : (j[1:0] == 2'h1) ? 8'h01 :
                    (j[1:0] == 2'h2) ? 8'hFF : 8'h7F);
            run_op(3'(i), 7'h7F, j[2], 11'h000, 5'h00);
         end
      end
      acc_load(8'h00);
      run_op(3'h3, 7'h00, 1'b0, 11'h700, 5'h00);
      run_op(3'h3, 7'h00, 1'b0, 11'h7A5, 5'h00);
      run_op(3'h3, 7'h00, 1'b0, 11'h0FF, 5'h00);
      // A low enable freezes the executor even with requests standing.
      @(posedge clk);
      clk_en        <= 1'b0;
      acc_load_en   <= 1'b1;
      acc_load_data <= ~m_acc;
      instr_op      <= 3'h4;
      instr_valid   <= 1'b1;
      repeat (3) @(posedge clk);
      clk_en        <= 1'b1;
      acc_load_en   <= 1'b0;
      instr_valid   <= 1'b0;
      #1;
      chk("frozen_acc", {8'h00, accumulator}, {8'h00, m_acc});
      chk("frozen_pc", {3'h0, program_counter}, {3'h0, m_pc});
      chk("frozen_ready", {15'h0000, instr_ready}, 16'h0001);
      for (i = 0; i < 4; i++) begin
         run_op(3'h4, 7'h00, 1'b0, i[0] ? 11'h7FF : 11'h000, {i[1:0], 3'h5});
      end
      for (i = 5; i < 8; i++) run_op(3'(i), 7'h00, 1'b0, 11'h000, 5'h00);
      repeat (200) begin
         if ($random(seed) % 4 == 0) acc_load(8'($random(seed)));
         run_op(3'($random(seed)), 7'($random(seed)), 1'($random(seed)),
                11'($random(seed)), 5'($random(seed)));
      end
      wrap_up();
   end
endmodule
